// ==== include/astc_pkg.sv ====
// Package with register map, field layout and encodings of the conversion timing control block.
// Notes on behaviour
// [RL1] Length code 0 or top bit gives eight.
// [RL2] Freeze: 00 run, 10 finish, 11 stop.
// [RL3] Writing timing control aborts the running sequence.
// [RL4] Sample time codes select 4..24 conversion clocks.
// [RL5] Conversion clock is bus over 2*(prescaler+1).
// [RL6] Unsigned results, full scale 255/1023/4095.
// [RL7] Length field resets to four conversions.
// [RL8] Freeze field lives in result format register.
// [RL9] Sample counter uses conversion clock; prescaler after abort.
package astc_pkg;
	localparam logic [7:0] ADDR_RESULT_FORMAT = 8'h03;
	localparam logic [7:0] ADDR_TIMING        = 8'h04;
	localparam logic [7:0] ADDR_START         = 8'h05;
	localparam logic [7:0] ADDR_STATUS        = 8'h08;
	localparam logic [7:0] ADDR_RESULT        = 8'h0c;
	localparam logic [7:0] FMT_RESET          = 8'h20;
	localparam logic [7:0] TIMING_RESET       = 8'h05;
	localparam int         SEQ_LSB            = 3;
	localparam int         FRZ_LSB            = 0;
	localparam int         SMP_LSB            = 5;
	localparam int         PRS_LSB            = 0;
	localparam int         RES_LSB            = 6;
	localparam logic [1:0] FRZ_CONTINUE       = 2'h0;
	localparam logic [1:0] FRZ_FINISH         = 2'h2;
	localparam logic [1:0] FRZ_IMMEDIATE      = 2'h3;
	localparam logic [1:0] RES_8              = 2'h0;
	localparam logic [1:0] RES_10             = 2'h1;
	localparam logic [11:0] FULL_8            = 12'h0ff;
	localparam logic [11:0] FULL_10           = 12'h3ff;
	localparam logic [11:0] FULL_12           = 12'hfff;
	localparam logic [1:0] RESP_OKAY          = 2'h0;
	localparam logic [1:0] RESP_SLVERR        = 2'h2;
	localparam int         CONV_CYCLES        = 10;

	typedef struct packed {
		logic [2:0] sample_time_select;
		logic [4:0] clock_prescaler_value;
	} astc_timing_t;

	typedef struct packed {
		logic [11:0] code;
		logic [3:0]  index;
	} astc_result_t;
endpackage

// ==== hw/astc_clkdiv.sv ====
// Divider that produces the one-cycle conversion clock enable.
`timescale 1ns/1ps
module astc_clkdiv #(
	parameter int PW = 5
) (
	// Clock and reset.
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Control.
	input  wire logic          restart,
	input  wire logic [PW-1:0] prescaler,
	// Enable out.
	output logic               tick
);
	logic [PW:0] cnt_q;
	logic [PW:0] limit;

	// One tick every 2*(prescaler+1) bus cycles.
	assign limit = {prescaler, 1'b1}; // RL5

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (restart) begin
			// Start one count in so the first tick after a restart is exactly one period away.
			cnt_q <= {{PW{1'b0}}, 1'b1}; // RL5
			tick  <= 1'b0;
		end else begin
			tick  <= (cnt_q == limit);
			cnt_q <= (cnt_q == limit) ? '0 : cnt_q + 1'b1;
		end
	end
endmodule

// ==== hw/astc_resmem.sv ====
// Small result memory with registered read data.
`timescale 1ns/1ps
module astc_resmem #(
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	// Clock.
	input  wire logic          aclk,
	// Write port.
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [11:0]   wdata,
	// Read port.
	input  wire logic [AW-1:0] raddr,
	output logic      [11:0]   rdata
);
	logic [11:0] mem [DEPTH];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ==== hw/astc_top.sv ====
// Sequence timing controller with AXI4-Lite register access.
`timescale 1ns/1ps
module astc_top #(
	parameter int PW = 5
) (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data.
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data.
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Debug breakpoint from another clock domain.
	input  wire logic        freeze_req,
	// Converter core.
	input  wire logic [11:0] core_code,
	output logic             core_sample_q,
	output logic             core_convert_q,
	output logic             seq_busy_q
);
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_FROZEN} astc_state_t;

	// Sequence length decode.
	function automatic logic [3:0] seq_len(input logic [3:0] c);
		seq_len = (c == 4'h0 || c[3]) ? 4'h8 : c; // RL1
	endfunction

	// Sample time decode in conversion clocks.
	function automatic logic [4:0] smp_len(input logic [2:0] c);
		case (c) // RL4
			3'h0: smp_len = 5'h04;
			3'h1: smp_len = 5'h06;
			3'h2: smp_len = 5'h08;
			3'h3: smp_len = 5'h0a;
			3'h4: smp_len = 5'h0c;
			3'h5: smp_len = 5'h10;
			3'h6: smp_len = 5'h14;
			default: smp_len = 5'h18;
		endcase
	endfunction

	// Clip the core result to the selected resolution.
	function automatic logic [11:0] clip(input logic [11:0] v, input logic [1:0] r);
		case (r) // RL6
			astc_pkg::RES_8:  clip = v & astc_pkg::FULL_8;
			astc_pkg::RES_10: clip = v & astc_pkg::FULL_10;
			default:          clip = v & astc_pkg::FULL_12;
		endcase
	endfunction

	logic [7:0]              fmt_q;
	astc_pkg::astc_timing_t  tim_q;
	astc_state_t             st_q;
	logic [4:0]              phase_q;
	logic [3:0]              conv_q;
	logic                    frz_m_q, frz_q;
	logic                    aw_hold_q, w_hold_q;
	logic [7:0]              awaddr_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic                    rd_pend_q;
	logic [7:0]              araddr_q;
	logic [2:0]              rd_idx_q;
	logic [11:0]             mem_rdata;
	logic                    tick;

	// Write channel decode.
	wire         aw_in     = s_axi_awvalid & s_axi_awready;
	wire         w_in      = s_axi_wvalid & s_axi_wready;
	wire         have_aw   = aw_hold_q | aw_in;
	wire         have_w    = w_hold_q | w_in;
	wire [7:0]   wr_addr   = aw_hold_q ? awaddr_q : s_axi_awaddr;
	wire [31:0]  wr_data   = w_hold_q ? wdata_q : s_axi_wdata;
	wire         wr_lane0  = w_hold_q ? wstrb_q[0] : s_axi_wstrb[0];
	wire         wr_fire   = have_aw & have_w & ~s_axi_bvalid;
	wire         wr_fmt    = wr_fire & wr_lane0 & (wr_addr == astc_pkg::ADDR_RESULT_FORMAT);
	wire         wr_tim    = wr_fire & wr_lane0 & (wr_addr == astc_pkg::ADDR_TIMING);
	wire         wr_start  = wr_fire & wr_lane0 & (wr_addr == astc_pkg::ADDR_START);
	wire         wr_mapped = (wr_addr == astc_pkg::ADDR_RESULT_FORMAT) | (wr_addr == astc_pkg::ADDR_TIMING) |
	                         (wr_addr == astc_pkg::ADDR_START);
	wire         abort     = wr_fmt | wr_tim | wr_start; // RL3

	// Control fields.
	wire [3:0]   len_code  = fmt_q[astc_pkg::SEQ_LSB +: 4];
	wire [1:0]   frz_mode  = fmt_q[astc_pkg::FRZ_LSB +: 2]; // RL8
	wire [1:0]   res_sel   = fmt_q[astc_pkg::RES_LSB +: 2];
	wire [3:0]   n_conv    = seq_len(len_code);
	wire [4:0]   n_smp     = smp_len(tim_q.sample_time_select);
	wire         frz_now   = frz_q & (frz_mode == astc_pkg::FRZ_IMMEDIATE); // RL2
	wire         frz_end   = frz_q & (frz_mode == astc_pkg::FRZ_FINISH); // RL2
	wire         seq_last  = (conv_q + 4'h1 == n_conv);

	// Read decode.
	wire [31:0]  rd_word =
		(araddr_q == astc_pkg::ADDR_RESULT_FORMAT) ? {24'h0, fmt_q} :
		(araddr_q == astc_pkg::ADDR_TIMING)        ? {24'h0, tim_q} :
		(araddr_q == astc_pkg::ADDR_STATUS)        ? {24'h0, seq_busy_q, st_q == ST_FROZEN, 2'h0, conv_q} :
		(araddr_q == astc_pkg::ADDR_RESULT)        ? {20'h0, mem_rdata} : 32'h0;
	wire         rd_ok   = (araddr_q == astc_pkg::ADDR_RESULT_FORMAT) | (araddr_q == astc_pkg::ADDR_TIMING) |
	                       (araddr_q == astc_pkg::ADDR_STATUS) | (araddr_q == astc_pkg::ADDR_RESULT) |
	                       (araddr_q == astc_pkg::ADDR_START);

	// Prescaler counter restarts on abort so the new divide applies cleanly.
	astc_clkdiv #(
		.PW (PW)
	) u_div (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.restart   (abort), // RL9
		.prescaler (tim_q.clock_prescaler_value),
		.tick      (tick)
	);

	astc_resmem #(
		.DEPTH (8),
		.AW    (3)
	) u_mem (
		.aclk  (aclk),
		.we    (st_q == ST_CONVERT && tick && phase_q == 5'h0 && !abort),
		.waddr (conv_q[2:0]),
		.wdata (clip(core_code, res_sel)),
		.raddr (rd_idx_q),
		.rdata (mem_rdata)
	);

	// Breakpoint synchroniser.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frz_m_q <= 1'b0;
			frz_q   <= 1'b0;
		end else begin
			frz_m_q <= freeze_req;
			frz_q   <= frz_m_q;
		end
	end

	// Write address and data capture.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
		end else begin
			if (aw_in) awaddr_q <= s_axi_awaddr;
			if (w_in) wdata_q <= s_axi_wdata;
			if (w_in) wstrb_q <= s_axi_wstrb;
			aw_hold_q <= have_aw & ~wr_fire;
			w_hold_q  <= have_w & ~wr_fire;
		end
	end

	// Write response and ready.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= astc_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= ~have_aw & ~s_axi_bvalid & ~(s_axi_awready & s_axi_awvalid);
			s_axi_wready  <= ~have_w & ~s_axi_bvalid & ~(s_axi_wready & s_axi_wvalid);
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? astc_pkg::RESP_OKAY : astc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fmt_q <= astc_pkg::FMT_RESET; // RL7
			tim_q <= astc_pkg::TIMING_RESET;
		end else begin
			if (wr_fmt) fmt_q <= wr_data[7:0];
			if (wr_tim) tim_q <= wr_data[7:0];
		end
	end

	// Read channel; every read, result included, waits one pending cycle before the data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= astc_pkg::RESP_OKAY;
			rd_pend_q     <= 1'b0;
			araddr_q      <= 8'h0;
			rd_idx_q      <= 3'h0;
		end else begin
			s_axi_arready <= ~rd_pend_q & ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				araddr_q  <= s_axi_araddr;
				rd_pend_q <= 1'b1;
			end else if (rd_pend_q) begin
				rd_pend_q    <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? astc_pkg::RESP_OKAY : astc_pkg::RESP_SLVERR;
				if (araddr_q == astc_pkg::ADDR_RESULT) rd_idx_q <= rd_idx_q + 3'h1;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Sequence engine stepped by the conversion clock enable.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q    <= ST_IDLE;
			phase_q <= 5'h0;
			conv_q  <= 4'h0;
		end else if (abort) begin // RL3
			st_q    <= wr_start ? ST_SAMPLE : ST_IDLE;
			phase_q <= n_smp;
			conv_q  <= 4'h0;
		end else if (frz_now && st_q != ST_IDLE) begin
			st_q <= ST_FROZEN; // RL2
		end else if (tick) begin // RL9
			case (st_q)
				ST_SAMPLE: begin
					if (phase_q <= 5'h1) begin
						st_q    <= ST_CONVERT;
						phase_q <= 5'(astc_pkg::CONV_CYCLES - 1);
					end else begin
						phase_q <= phase_q - 5'h1; // RL4
					end
				end
				ST_CONVERT: begin
					if (phase_q == 5'h0) begin
						conv_q <= conv_q + 4'h1;
						phase_q <= n_smp;
						if (seq_last) st_q <= ST_IDLE; // RL1
						else if (frz_end) st_q <= ST_FROZEN; // RL2
						else st_q <= ST_SAMPLE;
					end else begin
						phase_q <= phase_q - 5'h1;
					end
				end
				ST_FROZEN: begin
					// Resuming restarts sampling with the full selected length.
					if (!frz_q || frz_mode == astc_pkg::FRZ_CONTINUE) begin
						st_q    <= ST_SAMPLE;
						phase_q <= n_smp; // RL4
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Core strobes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_sample_q  <= 1'b0;
			core_convert_q <= 1'b0;
			seq_busy_q     <= 1'b0;
		end else begin
			core_sample_q  <= (st_q == ST_SAMPLE);
			core_convert_q <= (st_q == ST_CONVERT);
			seq_busy_q     <= (st_q != ST_IDLE);
		end
	end
endmodule

// ==== dv/astc_assertions.sv ====
// Checker for the bus handshake and the phase outputs of the timing controller.
`timescale 1ns/1ps
module astc_assertions #(
	parameter int PW = 5
) (
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus.
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Converter side.
	input wire logic        core_sample_q,
	input wire logic        core_convert_q,
	input wire logic        seq_busy_q
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire wr_hs  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire ar_hs  = s_axi_arvalid && s_axi_arready;
	wire ar_bad = !(s_axi_araddr inside {8'h03, 8'h04, 8'h05, 8'h08, 8'h0c});
	wire tm_wr  = wr_hs && s_axi_awaddr == astc_pkg::ADDR_TIMING && s_axi_wstrb[0];
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response changed before it was taken");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before it was taken");
	chk_b_answer: assert property (wr_hs |=> s_axi_bvalid)
		else $error("write response late");
	chk_r_answer: assert property (ar_hs |-> ##2 s_axi_rvalid)
		else $error("read data late");
	chk_r_slverr: assert property (ar_hs && ar_bad |-> ##2 s_axi_rresp == astc_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	chk_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	chk_phase_excl: assert property (!(core_sample_q && core_convert_q))
		else $error("sampling and converting together");
	chk_phase_busy: assert property (core_sample_q || core_convert_q |-> seq_busy_q)
		else $error("phase active outside a sequence");
	chk_abort_seq: assert property (tm_wr |-> ##[1:3] !seq_busy_q)
		else $error("timing write did not abort the sequence");
	cover property (seq_busy_q && !core_sample_q && !core_convert_q);
	cover property (ar_hs && ar_bad);
	cover property (tm_wr && seq_busy_q);
endmodule

bind astc_top astc_assertions #(.PW(PW)) i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_sample_q,
	.core_convert_q, .seq_busy_q);

// ==== dv/astc_core_model.sv ====
// Behavioural converter core that answers every conversion with a full-scale code.
`timescale 1ns/1ps
module astc_core_model (
	// Clock.
	input wire logic    aclk,
	// Phase level.
	input wire logic    core_convert_q,
	// Result.
	output logic [11:0] core_code
);
	initial core_code = 12'h5a5;
	// Outside a conversion the code is not held, so it toggles every cycle.
	always @(posedge aclk) core_code <= core_convert_q ? astc_pkg::FULL_12 : ~core_code;
endmodule

// ==== dv/tb_adc_sequence_timing_control.sv ====
// Testbench for the sequence timing controller.
`timescale 1ns/1ps
module tb_adc_sequence_timing_control;
	logic        aclk = 1'b0, aresetn = 1'b0, freeze_req = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        core_sample_q, core_convert_q, seq_busy_q;
	logic [11:0] core_code;
	int          failures = 0, checks = 0, cyc = 0;
	int          st_tab [8] = '{4, 6, 8, 10, 12, 16, 20, 24};
	logic [1:0]  fm [3] = '{astc_pkg::FRZ_CONTINUE, astc_pkg::FRZ_FINISH, astc_pkg::FRZ_IMMEDIATE};
	logic [11:0] fs [3] = '{astc_pkg::FULL_8, astc_pkg::FULL_10, astc_pkg::FULL_12};

	always #25 aclk = ~aclk;
	astc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .freeze_req, .core_code,
		.core_sample_q, .core_convert_q, .seq_busy_q);
	astc_core_model i_core (.aclk, .core_convert_q, .core_code);

	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ad = 0;
		bit wd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (s_axi_awready && !ad) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !wd) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Starts a sequence and counts conversions and sampling cycles until it ends.
	task automatic run(output int nconv, output int nsamp);
		logic [1:0] r;
		logic pc = 1'b0;
		nconv = 0;
		nsamp = 0;
		wr(astc_pkg::ADDR_START, 32'h0, r);
		for (int i = 0; i < 4 || seq_busy_q; i++) begin
			@(posedge aclk);
			nsamp += core_sample_q;
			if (core_convert_q && !pc) nconv++;
			pc = core_convert_q;
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			finish_test();
		end
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int nc, ns;
		astc_pkg::astc_timing_t t;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(astc_pkg::ADDR_RESULT_FORMAT, d, r);
		cmp("length reset", 32'h4, 32'(d[6:3]));
		rd(astc_pkg::ADDR_TIMING, d, r);
		cmp("timing reset", 32'(astc_pkg::TIMING_RESET), d);
		rd(8'h10, d, r);
		cmp("unmapped read", 32'(astc_pkg::RESP_SLVERR), 32'(r));
		wr(8'h20, 32'h0, r);
		cmp("unmapped write", 32'(astc_pkg::RESP_SLVERR), 32'(r));
		wr(astc_pkg::ADDR_TIMING, 32'h0, r);
		for (int c = 0; c < 16; c++) begin
			wr(astc_pkg::ADDR_RESULT_FORMAT, 32'(c) << astc_pkg::SEQ_LSB, r);
			run(nc, ns);
			cmp("conversions", (c == 0 || c > 7) ? 8 : c, nc);
		end
		wr(astc_pkg::ADDR_RESULT_FORMAT, 32'h1 << astc_pkg::SEQ_LSB, r);
		for (int s = 0; s < 8; s++) begin
			t.sample_time_select = 3'(s);
			t.clock_prescaler_value = 5'(s * 4 + 3);
			wr(astc_pkg::ADDR_TIMING, 32'(t), r);
			run(nc, ns);
			cmp("sample cycles", st_tab[s] * 2 * (s * 4 + 4), ns);
		end
		rd(astc_pkg::ADDR_TIMING, d, r);
		cmp("timing readback", 32'(t), d);
		wr(astc_pkg::ADDR_TIMING, 32'h0, r);
		wr(astc_pkg::ADDR_RESULT_FORMAT, 32'h0, r);
		wr(astc_pkg::ADDR_START, 32'h0, r);
		repeat (40) @(posedge aclk);
		cmp("busy before abort", 32'h1, 32'(seq_busy_q));
		wr(astc_pkg::ADDR_TIMING, 32'h0, r);
		@(posedge aclk);
		cmp("busy after abort", 32'h0, 32'(seq_busy_q));
		for (int m = 0; m < 3; m++) begin
			wr(astc_pkg::ADDR_RESULT_FORMAT, (32'h2 << astc_pkg::SEQ_LSB) | 32'(fm[m]), r);
			wr(astc_pkg::ADDR_START, 32'h0, r);
			while (!core_convert_q) @(posedge aclk);
			freeze_req <= 1'b1;
			repeat (10) @(posedge aclk);
			cmp("convert in freeze", 32'(fm[m] != astc_pkg::FRZ_IMMEDIATE), 32'(core_convert_q));
			repeat (60) @(posedge aclk);
			cmp("busy in freeze", 32'(fm[m] != astc_pkg::FRZ_CONTINUE), 32'(seq_busy_q));
			freeze_req <= 1'b0;
			while (seq_busy_q) @(posedge aclk);
		end
		// Each resolution in turn; the result index steps by one per read.
		for (int k = 0; k < 3; k++) begin
			wr(astc_pkg::ADDR_RESULT_FORMAT, 32'(k) << astc_pkg::RES_LSB, r);
			run(nc, ns);
			rd(astc_pkg::ADDR_RESULT, d, r);
			cmp("result full scale", 32'(fs[k]), d);
		end
		finish_test();
	end
endmodule
